/* hw/eeprom_pkg.sv */
// Overview of operation
// RULE1 - Sample SDA on SCL rising edge; change output only after SCL falling edge.
// RULE2 - Zero pulls SDA low, one releases it; output is open drain.
// RULE3 - Undriven write-protect input reads low, memory unprotected.
// RULE4 - Master keeps SDA stable while SCL high during data bits.
// RULE5 - SDA falling while SCL high is start; precedes every command.
// RULE6 - SDA rising while SCL high is stop; ends every command.
// RULE7 - Ignore all traffic until a start condition has been seen.
// RULE8 - Receive 8-bit slave address; answer only if top nibble is 1010.
// RULE9 - Next three address bits must match the select pins.
// RULE10 - Larger variant uses one of those bits as array address bit 8.
// RULE11 - That bit sits where the lowest select pin is compared.
// RULE12 - Address LSB one means read, zero means write.
// RULE13 - Acknowledge matching slave address by holding SDA low in 9th clock.
// RULE14 - In write direction acknowledge byte address and each data byte.
// RULE15 - In read direction send eight bits, release SDA in 9th clock.
// RULE16 - Keep sending while master acknowledges; no-ack then stop ends read.
// RULE17 - Byte write: start, address, byte address, data, stop, acks between.
// RULE18 - Internal write cycle starts on the stop ending a write.
// RULE19 - During internal write leave SDA undriven, answer nothing.
// RULE20 - Page write accepts up to 16 bytes in one write cycle.
// RULE21 - After each write byte increment only low four address bits.
// RULE22 - Beyond sixteen bytes the in-page address wraps, overwriting earlier bytes.
// RULE23 - On stop commit all buffered page bytes in one write cycle.
// RULE24 - Do not acknowledge write-direction address while internal write runs.
// RULE25 - Acknowledge polling address once the internal write has finished.
// RULE26 - With protect high refuse writes to the upper memory half.
// RULE27 - Upper half means top array address bit is one.
// RULE28 - Sample protect on last SCL fall before first data byte; nack if high.
// RULE29 - Read address without address phase returns byte at current pointer.
// RULE30 - Random read: dummy write loads address, repeated start, read address.
// RULE31 - Sequential reads increment full address, wrap at end of memory.
package eeprom_pkg;
    localparam int clk_freq_hz = 200_000_000;
    localparam int internal_write_cycle_time_ms = 5;
    localparam int write_cycles = clk_freq_hz / 1000 * internal_write_cycle_time_ms;
    localparam logic [3:0] device_code = 4'ha;
    localparam int page_bytes = 16;
    localparam int fifo_depth = 16;
    localparam logic [7:0] erased_value = 8'hff;

    typedef struct packed {
        logic [3:0] offset;
        logic [7:0] data;
    } page_word_type;

    typedef struct packed {
        logic scl;
        logic sda;
    } bus_pins_type;

    typedef enum logic [2:0] {
        st_idle = 3'b000,
        st_addr = 3'b001,
        st_ack = 3'b010,
        st_rx = 3'b011,
        st_tx = 3'b100,
        st_mack = 3'b101,
        st_skip = 3'b110
    } phase_type;
endpackage

/* hw/page_fifo.sv */
`timescale 1ns/1ps
module page_fifo #(
    parameter int width = 12,
    parameter int depth = 16
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire logic flush, // Drop contents
    input wire logic [width-1:0] in_data, // Write data
    input wire logic in_valid, // Write request
    output logic in_ready, // Not full
    output logic [width-1:0] out_data, // Head word
    output logic out_valid, // Not empty
    input wire logic out_ready // Head consumed
);
    localparam int aw = $clog2(depth);
    logic [width-1:0] mem_q [depth];
    logic [aw:0] wr_q;
    logic [aw:0] rd_q;
    logic push;

    // Full and empty from pointer compare
    assign in_ready = !((wr_q[aw] != rd_q[aw]) && (wr_q[aw-1:0] == rd_q[aw-1:0]));
    assign out_valid = (wr_q != rd_q);
    assign out_data = mem_q[rd_q[aw-1:0]];

    // A pop in the same cycle frees a slot, so a full buffer still takes the word
    assign push = in_valid && (in_ready || out_ready);

    // Storage
    always_ff @(posedge clk)
    begin
        if (push)
        begin
            mem_q[wr_q[aw-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk)
    begin
        if (srst || flush)
        begin
            wr_q <= '0;
            rd_q <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_q <= wr_q + 1'b1;
            end
            if (out_valid && out_ready)
            begin
                rd_q <= rd_q + 1'b1;
            end
        end
    end
endmodule

/* hw/serial_eeprom_i2c_slave.sv */
`timescale 1ns/1ps
module serial_eeprom_i2c_slave #(
    parameter bit large_variant = 1'b0, // 512-byte array when set
    parameter int write_time_cycles = eeprom_pkg::write_cycles // Internal write length
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire eeprom_pkg::bus_pins_type pins_in, // Raw SCL and SDA levels
    output logic sda_out, // SDA output level, always low
    output logic sda_oe, // SDA pulled low while high
    input wire logic select_pin_low, // Select pin 0
    input wire logic select_pin_mid, // Select pin 1
    input wire logic select_pin_high, // Select pin 2
    input wire logic write_protect, // Protect upper half
    output logic write_busy_q // Internal write in progress
);
    import eeprom_pkg::*;

    localparam int aw = 9;
    logic [7:0] array_q [512];
    logic [1:0] scl_s_q, sda_s_q, wp_s_q;
    logic [2:0] sel_s_q [2];
    logic scl_q, sda_q;
    logic scl_rise, scl_fall, start_det, stop_det;
    phase_type phase_q;
    logic [3:0] bit_q;
    logic [7:0] shift_q;
    logic read_q, addr_phase_q, wp_hit_q, wrote_q, nack_q, dev_ack_q;
    logic [aw-1:0] ptr_q;
    logic [aw-1:0] top_mask;
    logic [31:0] wcount_q;
    logic drive_low;
    page_word_type fifo_in, fifo_out;
    logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready, fifo_flush;
    logic addr_match;
    logic [aw-1:0] next_ptr;

    assign top_mask = large_variant ? 9'h1ff : 9'h0ff;

    // Two-flop synchronisers on all pins
    always_ff @(posedge clk)
    begin
        scl_s_q <= {scl_s_q[0], pins_in.scl};
        sda_s_q <= {sda_s_q[0], pins_in.sda};
        wp_s_q <= {wp_s_q[0], write_protect};
        sel_s_q[0] <= {select_pin_high, select_pin_mid, select_pin_low};
        sel_s_q[1] <= sel_s_q[0];
    end

    // Delayed synchronised levels for edge finding
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end
        else
        begin
            scl_q <= scl_s_q[1];
            sda_q <= sda_s_q[1];
        end
    end

    assign scl_rise = scl_s_q[1] && !scl_q; // RULE1
    assign scl_fall = !scl_s_q[1] && scl_q; // RULE1
    assign start_det = scl_s_q[1] && scl_q && sda_q && !sda_s_q[1]; // RULE5 RULE4
    assign stop_det = scl_s_q[1] && scl_q && !sda_q && sda_s_q[1]; // RULE6 RULE4

    // Address match on device code and select pins
    always_comb
    begin
        addr_match = (shift_q[7:4] == device_code); // RULE8
        if (large_variant)
        begin
            addr_match = addr_match && (shift_q[3:2] == sel_s_q[1][2:1]); // RULE10 RULE11
        end
        else
        begin
            addr_match = addr_match && (shift_q[3:1] == sel_s_q[1]); // RULE9
        end
        addr_match = addr_match && !write_busy_q; // RULE19 RULE24 RULE25
    end

    // Page write buffer
    page_fifo #(
        .width(12),
        .depth(fifo_depth)
    ) u_fifo (
        .clk(clk),
        .srst(srst),
        .flush(fifo_flush),
        .in_data(fifo_in),
        .in_valid(fifo_in_valid),
        .in_ready(fifo_in_ready),
        .out_data(fifo_out),
        .out_valid(fifo_out_valid),
        .out_ready(fifo_out_ready)
    );

    // Protocol phase machine
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            phase_q <= st_idle;
            bit_q <= 4'h0;
            shift_q <= 8'h00;
            read_q <= 1'b0;
            addr_phase_q <= 1'b0;
            nack_q <= 1'b0;
            dev_ack_q <= 1'b0;
        end
        else if (stop_det)
        begin
            phase_q <= st_idle; // RULE6
        end
        else if (start_det)
        begin
            phase_q <= st_addr; // RULE5 RULE7
            bit_q <= 4'h0;
            addr_phase_q <= 1'b0;
        end
        else
        begin
            case (phase_q)
                st_idle:
                begin
                    bit_q <= 4'h0; // RULE7
                end
                st_addr, st_rx:
                begin
                    if (scl_rise)
                    begin
                        shift_q <= {shift_q[6:0], sda_s_q[1]}; // RULE1
                        bit_q <= bit_q + 4'h1;
                    end
                    else if (scl_fall && bit_q == 4'h8)
                    begin
                        bit_q <= 4'h0;
                        if (phase_q == st_addr)
                        begin
                            read_q <= shift_q[0]; // RULE12
                            dev_ack_q <= 1'b1;
                            nack_q <= !addr_match;
                            phase_q <= addr_match ? st_ack : st_skip;
                        end
                        else
                        begin
                            nack_q <= addr_phase_q && wp_hit_q; // RULE28
                            phase_q <= st_ack; // RULE14
                        end
                    end
                end
                st_ack:
                begin
                    if (scl_fall)
                    begin
                        phase_q <= nack_q ? st_skip : (read_q ? st_tx : st_rx); // RULE15
                        if (!read_q && !nack_q && !dev_ack_q)
                        begin
                            addr_phase_q <= 1'b1;
                        end
                        dev_ack_q <= 1'b0;
                        shift_q <= array_q[ptr_q]; // RULE29
                    end
                end
                st_tx:
                begin
                    if (scl_fall)
                    begin
                        shift_q <= {shift_q[6:0], 1'b1};
                        bit_q <= bit_q + 4'h1;
                        if (bit_q == 4'h7)
                        begin
                            phase_q <= st_mack; // RULE15
                            bit_q <= 4'h0;
                        end
                    end
                end
                st_mack:
                begin
                    if (scl_rise)
                    begin
                        nack_q <= sda_s_q[1];
                    end
                    else if (scl_fall)
                    begin
                        phase_q <= nack_q ? st_skip : st_tx; // RULE16
                        shift_q <= array_q[next_ptr]; // RULE31
                    end
                end
                st_skip:
                begin
                    bit_q <= 4'h0;
                end
                default:
                begin
                    phase_q <= st_idle;
                end
            endcase
        end
    end

    // Address pointer updates
    always_comb
    begin
        next_ptr = ptr_q;
        if (phase_q == st_ack && scl_fall && !nack_q && !read_q && !dev_ack_q)
        begin
            if (!addr_phase_q)
            begin
                next_ptr = {(large_variant ? ptr_q[aw-1] : 1'b0), shift_q} & top_mask;
            end
            else
            begin
                next_ptr = {ptr_q[aw-1:4], ptr_q[3:0] + 4'h1}; // RULE21 RULE22
            end
        end
        else if (phase_q == st_mack && scl_fall)
        begin
            next_ptr = (ptr_q + 9'h001) & top_mask; // RULE31
        end
        else if (phase_q == st_ack && scl_fall && read_q)
        begin
            next_ptr = ptr_q;
        end
    end

    // Pointer register; bit 8 from slave address on large variant
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            ptr_q <= 9'h000;
        end
        else if (phase_q == st_addr && scl_fall && bit_q == 4'h8 && addr_match && large_variant)
        begin
            ptr_q <= {shift_q[1], ptr_q[7:0]}; // RULE10 RULE11
        end
        else
        begin
            ptr_q <= next_ptr; // RULE30
        end
    end

    // Write protect strobe before first data byte
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wp_hit_q <= 1'b0;
        end
        else if (phase_q == st_ack && scl_fall && !read_q && !addr_phase_q && !dev_ack_q)
        begin
            wp_hit_q <= wp_s_q[1] && next_ptr[large_variant ? 8 : 7]; // RULE26 RULE27 RULE28 RULE3
        end
    end

    // Buffer data bytes during write
    assign fifo_in.offset = ptr_q[3:0];
    assign fifo_in.data = shift_q;
    assign fifo_in_valid = (phase_q == st_rx) && scl_fall && bit_q == 4'h8 && addr_phase_q
        && !wp_hit_q; // RULE20
    assign fifo_flush = start_det && !write_busy_q && !wrote_q;

    // Track a write command awaiting stop
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            wrote_q <= 1'b0;
        end
        else if (stop_det)
        begin
            wrote_q <= 1'b0;
        end
        else if (fifo_in_valid)
        begin
            wrote_q <= 1'b1; // RULE17
        end
    end

    // Internal write timer and commit drain
    assign fifo_out_ready = (write_busy_q && fifo_out_valid)
        || (fifo_in_valid && !fifo_in_ready); // RULE22
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            write_busy_q <= 1'b0;
            wcount_q <= 32'h0;
        end
        else if (stop_det && wrote_q)
        begin
            write_busy_q <= 1'b1; // RULE18 RULE23
            wcount_q <= 32'(write_time_cycles);
        end
        else if (write_busy_q)
        begin
            if (wcount_q <= 32'h1)
            begin
                write_busy_q <= 1'b0; // RULE25
            end
            wcount_q <= wcount_q - 32'h1;
        end
    end

    // Commit buffered bytes into the array, last arrival wins
    always_ff @(posedge clk)
    begin
        if (write_busy_q && fifo_out_valid)
        begin
            array_q[{ptr_q[aw-1:4], fifo_out.offset}] <= fifo_out.data; // RULE22 RULE23
        end
    end

    // Open-drain SDA drive, changes only after SCL fall
    always_comb
    begin
        drive_low = 1'b0;
        if (phase_q == st_ack)
        begin
            drive_low = !nack_q; // RULE13 RULE14
        end
        else if (phase_q == st_tx)
        begin
            drive_low = !shift_q[7]; // RULE2
        end
    end

    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sda_oe <= 1'b0;
            sda_out <= 1'b0;
        end
        else
        begin
            sda_oe <= drive_low && !start_det && !stop_det; // RULE2 RULE19
            sda_out <= 1'b0; // RULE2
        end
    end
endmodule

/* testbench/eeprom_checker_assertions.sv */
`timescale 1ns/1ps
module eeprom_checker
    import eeprom_pkg::*;
#(
    parameter int write_time_cycles = 200
) (
    input wire logic clk, // System clock
    input wire logic srst, // Synchronous reset
    input wire eeprom_pkg::bus_pins_type pins_in, // Bus levels
    input wire logic sda_out, // SDA output level
    input wire logic sda_oe, // SDA pull-down enable
    input wire logic select_pin_low, // Select pin 0
    input wire logic select_pin_mid, // Select pin 1
    input wire logic select_pin_high, // Select pin 2
    input wire logic write_protect, // Upper half protect
    input wire logic write_busy_q // Internal write running
);
    default clocking @(posedge clk);
    endclocking
    default disable iff (srst);

    logic [31:0] busy_cnt_q;
    logic start_seen_q;

    // Length of the current internal write
    always_ff @(posedge clk)
    begin
        if (srst || !write_busy_q)
            busy_cnt_q <= 32'h0;
        else
            busy_cnt_q <= busy_cnt_q + 32'h1;
    end

    // Remembers a start since reset
    always_ff @(posedge clk)
    begin
        if (srst)
            start_seen_q <= 1'b0;
        else if (pins_in.scl && $fell(pins_in.sda))
            start_seen_q <= 1'b1;
    end

    a_drive_low_only: assert property (sda_oe |-> sda_out == 1'b0)
        else $error("sda driven high");
    a_change_scl_low: assert property ($changed(sda_oe) |-> !pins_in.scl)
        else $error("sda changed while scl high");
    a_busy_bus_quiet: assert property (write_busy_q |-> !sda_oe)
        else $error("sda driven during internal write");
    a_busy_on_stop: assert property ($rose(write_busy_q) |-> pins_in.scl && pins_in.sda)
        else $error("internal write began outside a stop");
    a_busy_length: assert property ($fell(write_busy_q) |-> busy_cnt_q == 32'(write_time_cycles))
        else $error("internal write length wrong");
    a_busy_hold: assert property ($rose(write_busy_q) |=> write_busy_q [*8])
        else $error("internal write dropped early");
    a_start_first: assert property ($rose(sda_oe) |-> start_seen_q)
        else $error("sda driven before any start");
    a_reset_quiet: assert property (disable iff (1'b0) srst |=> !sda_oe && !write_busy_q)
        else $error("outputs active after reset");
endmodule

bind serial_eeprom_i2c_slave eeprom_checker #(.write_time_cycles(write_time_cycles)) chk (
    .clk(clk),
    .srst(srst),
    .pins_in(pins_in),
    .sda_out(sda_out),
    .sda_oe(sda_oe),
    .select_pin_low(select_pin_low),
    .select_pin_mid(select_pin_mid),
    .select_pin_high(select_pin_high),
    .write_protect(write_protect),
    .write_busy_q(write_busy_q)
);

/* testbench/i2c_master_model.sv */
`timescale 1ns/1ps
module i2c_master_model (
    output logic scl, // Bus clock, idle high
    output logic sda_low, // Pulls SDA low while high
    input wire logic sda, // Resolved SDA level
    output logic [8:0] result, // Last ack or read byte
    output int result_count // Bumped per result
);
    // Bus idle: clock still and high, data released
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
        result = 9'h0;
        result_count = 0;
    end

    // Start or repeated start, leaves clock low
    task automatic start();
        sda_low = 1'b0;
        #20 scl = 1'b1;
        #20 sda_low = 1'b1;
        #20 scl = 1'b0;
        #20;
    endtask

    // Stop, leaves bus idle
    task automatic stop();
        sda_low = 1'b1;
        #20 scl = 1'b1;
        #20 sda_low = 1'b0;
        #40;
    endtask

    // One clock: data set while low, sampled while high
    task automatic bit_cycle(input logic out_bit, output logic in_bit);
        sda_low = !out_bit;
        #20 scl = 1'b1;
        #20 in_bit = sda;
        #20 scl = 1'b0;
        #20;
    endtask

    // Byte out, MSB first, then the slave's ack
    task automatic send_byte(input logic [7:0] b);
        logic level;
        for (int i = 7; i >= 0; i--)
            bit_cycle(b[i], level);
        bit_cycle(1'b1, level);
        result = {1'b1, 7'h0, !level};
        result_count++;
    endtask

    // Byte in, then ack to continue or no ack to end
    task automatic recv_byte(input logic more);
        logic [7:0] d;
        logic level;
        for (int i = 7; i >= 0; i--)
            bit_cycle(1'b1, d[i]);
        bit_cycle(!more, level);
        result = {1'b0, d};
        result_count++;
    endtask
endmodule

/* testbench/serial_eeprom_i2c_slave_tb.sv */
`timescale 1ns/1ps
module serial_eeprom_i2c_slave_tb;
    import eeprom_pkg::*;
    logic clk;
    logic srst;
    logic scl;
    logic sda_low;
    logic sda_out;
    logic sda_oe;
    logic write_busy_q;
    logic [2:0] sel;
    logic write_protect;
    logic [8:0] result;
    int result_count;
    int mismatches;
    int compares;
    logic [8:0] expq[$];
    logic [7:0] page[16];
    logic [7:0] first_byte;
    bus_pins_type pins;
    wire sda = !(sda_low || sda_oe);

    assign pins = {scl, sda};

    serial_eeprom_i2c_slave #(.large_variant(1'b0), .write_time_cycles(200)) dut (
        .clk(clk),
        .srst(srst),
        .pins_in(pins),
        .sda_out(sda_out),
        .sda_oe(sda_oe),
        .select_pin_low(sel[0]),
        .select_pin_mid(sel[1]),
        .select_pin_high(sel[2]),
        .write_protect(write_protect),
        .write_busy_q(write_busy_q)
    );

    i2c_master_model host (
        .scl(scl),
        .sda_low(sda_low),
        .sda(sda),
        .result(result),
        .result_count(result_count)
    );

    // 200 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic final_report();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic check(input string name, input logic [8:0] seen, input logic [8:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Each ack or read byte is matched against the oldest note
    always @(result_count)
    begin
        check("bus result", result, expq.size() ? expq.pop_front() : 9'bx);
    end

    function automatic logic [7:0] dev(input logic rw);
        return {4'ha, sel, rw};
    endfunction

    task automatic cmd(input logic [7:0] b, input logic ack);
        expq.push_back({1'b1, 7'h0, ack});
        host.send_byte(b);
    endtask

    task automatic rd(input logic [7:0] d, input logic more);
        expq.push_back({1'b0, d});
        host.recv_byte(more);
    endtask

    task automatic addr_phase(input logic [7:0] a);
        host.start();
        cmd(dev(1'b0), 1'b1);
        cmd(a, 1'b1);
    endtask

    task automatic read_at(input logic [7:0] a);
        addr_phase(a);
        host.start();
        cmd(dev(1'b1), 1'b1);
    endtask

    // Bounded wait for the internal write to end
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy_q !== 1'b0 && n < 400)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 400)
        begin
            mismatches++;
            final_report();
        end
    endtask

    initial
    begin
        srst = 1'b1;
        sel = 3'h0;
        write_protect = 1'b0;
        void'($urandom(34492));
        repeat (5) @(posedge clk);
        #1 srst = 1'b0;
        sel = 3'($urandom());
        repeat (8) @(posedge clk);
        #1;
        // Byte write, polling while busy, random read back
        first_byte = 8'($urandom());
        addr_phase(8'h00);
        cmd(first_byte, 1'b1);
        host.stop();
        host.start();
        cmd(dev(1'b0), 1'b0);
        host.stop();
        wait_idle();
        read_at(8'h00);
        rd(first_byte, 1'b0);
        host.stop();
        $display("test byte write done");
        // Wrong device code, then each select bit wrong
        for (int i = 0; i < 4; i++)
        begin
            host.start();
            cmd(i == 0 ? {4'h2, sel, 1'b0} : {4'ha, sel ^ 3'(1 << (i - 1)), 1'b0}, 1'b0);
            host.stop();
        end
        $display("test address match done");
        // Seventeen bytes from offset 5 wrap and overwrite inside the page
        addr_phase(8'hf5);
        for (int i = 0; i < 17; i++)
        begin
            page[(i + 5) % 16] = 8'($urandom());
            cmd(page[(i + 5) % 16], 1'b1);
        end
        host.stop();
        #100 check("busy", {8'h0, write_busy_q}, 9'h1);
        wait_idle();
        read_at(8'hfe);
        rd(page[14], 1'b0);
        host.stop();
        host.start();
        cmd(dev(1'b1), 1'b1);
        rd(page[15], 1'b0);
        host.stop();
        read_at(8'hff);
        rd(page[15], 1'b1);
        rd(first_byte, 1'b0);
        host.stop();
        read_at(8'hf0);
        for (int i = 0; i < 16; i++)
            rd(page[i], i < 15);
        host.stop();
        $display("test page write done");
        // Protect refuses upper half only
        @(posedge clk);
        #1 write_protect = 1'b1;
        addr_phase(8'h80);
        cmd(first_byte, 1'b0);
        host.stop();
        #100 check("busy", {8'h0, write_busy_q}, 9'h0);
        addr_phase(8'h05);
        cmd(page[3], 1'b1);
        host.stop();
        wait_idle();
        @(posedge clk);
        #1 write_protect = 1'b0;
        read_at(8'h05);
        rd(page[3], 1'b0);
        host.stop();
        $display("test write protect done");
        check("pending results", 9'(expq.size()), 9'h0);
        final_report();
    end
endmodule
